// ==== hcfi_pkg.sv ====
// Purpose: shared constants and types for the interrupt-gate and frame-interval register bank
// Assumes: 32-bit AHB-Lite register access, one aligned word per register index
// Notes: byte address of a register is its index times four
package hcfi_pkg;
	// register indexes, byte address = index << ADDR_LSB
	localparam logic [29:0] IDX_CMD_STATUS = 30'h02;
	localparam logic [29:0] IDX_IRQ_STATUS = 30'h03;
	localparam logic [29:0] IDX_IRQ_ENABLE = 30'h04;
	localparam logic [29:0] IDX_IRQ_DISABLE = 30'h05;
	localparam logic [29:0] IDX_FRAME_INTERVAL = 30'h0D;
	localparam int ADDR_LSB = 2;

	// enable / disable / status layout
	localparam int BIT_MASTER = 31;
	localparam int BIT_HUB = 6;
	localparam int BIT_WRAP = 5;
	localparam int BIT_FATAL = 4;
	localparam int BIT_RESUME = 3;
	localparam int BIT_FSTART = 2;
	localparam int BIT_OVERRUN = 0;
	localparam int NUM_EVT = 7;
	localparam logic [31:0] IRQ_LAYOUT_MASK = 32'h8000007D;
	localparam logic [6:0] EVENT_MASK = 7'h7D;
	localparam logic [31:0] IRQ_ENABLE_RESET = 32'h80000000;

	// command status
	localparam int BIT_CTRL_RESET = 0;

	// frame interval register
	localparam logic [13:0] FI_NOMINAL = 14'h2EDF;
	localparam logic [31:0] FMI_RESET = 32'h00002EDF;
	localparam logic [31:0] FMI_WRITE_MASK = 32'hFFFF3FFF;

	// bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

	typedef struct packed {
		logic toggle;
		logic [14:0] largest;
		logic [1:0] rsvd;
		logic [13:0] interval;
	} hcfi_fmi_s;

	// one bit per event, at the same position as in the enable register
	typedef struct packed {
		logic hub_change;
		logic frame_wrap;
		logic fatal;
		logic resume;
		logic frame_start;
		logic unused1;
		logic overrun;
	} hcfi_evt_s;

	typedef enum logic {BUS_IDLE, BUS_EXEC} hcfi_bus_e;
endpackage

// ==== hcfi_irq_unit.sv ====
// Purpose: sticky event status with read-clear and the gated interrupt line
// Assumes: events are one-cycle pulses on the register clock
// Notes: an event in the clearing cycle survives the clear
`timescale 1ns/1ps
`default_nettype none
module hcfi_irq_unit
	import hcfi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [NUM_EVT-1:0] evt,
	input wire logic rd_clr,
	input wire logic [31:0] enables,
	output logic [NUM_EVT-1:0] status_q,
	output logic irq_q
);
	logic [NUM_EVT-1:0] status_d;
	logic irq_d;

	genvar g;
	generate
		for (g = 0; g < NUM_EVT; g++) begin : g_evt
			// set beats clear so a pulse during the read is not lost
			always_comb begin
				status_d[g] = EVENT_MASK[g] & (evt[g] | (status_q[g] & ~rd_clr));
			end
		end
	endgenerate

	always_comb begin
		irq_d = enables[BIT_MASTER] & (|(status_d & enables[NUM_EVT-1:0])); // [R18]
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_q <= '0;
			irq_q <= 1'b0;
		end else begin
			status_q <= status_d;
			irq_q <= irq_d;
		end
	end
endmodule // hcfi_irq_unit
`default_nettype wire

// ==== hcfi_regbank.sv ====
// Purpose: interrupt enable/disable pair and frame interval register behind AHB-Lite
// Assumes: single slave, whole-word single transfers, events and frame start synchronous to MCLK
// Notes: every transfer takes one wait state; reads and writes act at the first data-phase edge
//
// What this block and its software do
// (R1) writing one to master bit 31 of disable turns off all event interrupts
// (R2) master interrupt enable is set after hardware or software reset
// (R3) writing one to bit 6 stops hub change interrupts, zero leaves it
// (R4) ones at bits 5 and 4 stop frame wrap and fatal error interrupts
// (R5) ones at bits 3 and 2 stop resume and frame start interrupts
// (R6) one at bit 0 stops overrun interrupts; bit 1 and 30..7 are reserved
// (R7) 14-bit frame interval in low bits gives bit times between frame starts
// (R8) frame interval nominal reset value is 11999 bit times
// (R9) controller reset command forces the interval field back to nominal
// (R10) software saves the interval before resetting the controller
// (R11) software may restore the saved interval after reset completes
// (R12) software flips the toggle bit on each new interval; plain bit, resets zero
// (R13) each frame start loads the 15-bit largest packet field into its counter
// (R14) software computes and writes the largest packet field; it resets to zero
// (R15) a new interval written is taken up at any following frame start
// (R16) the interval register sits at index 0DH for read and write
// (R17) ones written to disable clear enables; disable reads return enables; index 05H
// (R18) interrupt only when status, its enable and the master enable are all set
// (R19) whole interval register resets to 0x00002EDF, reserved bits read zero
`timescale 1ns/1ps
`default_nettype none
module hcfi_regbank
	import hcfi_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire hcfi_pkg::hcfi_evt_s EVT,
	output logic IRQ,
	output logic CTRL_RESET_PULSE,
	output logic [13:0] ACTIVE_INTERVAL,
	output logic [14:0] LARGEST_PKT_CNT
);
	import hcfi_pkg::*;

	hcfi_bus_e bus_q, bus_d;
	logic [29:0] idx_q, idx_d;
	logic wr_q, wr_d;
	logic ready_q, ready_d;
	logic [31:0] rdata_q, rdata_d;
	logic resp_q, resp_d;
	logic [31:0] en_q, en_d;
	hcfi_fmi_s fmi_q, fmi_d;
	logic cres_q, cres_d;
	logic [13:0] act_q, act_d;
	logic [14:0] lpc_q, lpc_d;
	logic [NUM_EVT-1:0] status;
	logic irq;
	logic accept, exec, exec_wr, exec_rd;
	logic [31:0] wbits;

	// HSIZE is not decoded: only whole-word transfers are issued on this bus
	assign accept = HSEL & HREADY & (HTRANS == HTRANS_NONSEQ);
	assign exec = (bus_q == BUS_EXEC);
	assign exec_wr = exec & wr_q;
	assign exec_rd = exec & ~wr_q;
	assign wbits = HWDATA & IRQ_LAYOUT_MASK;

	// bus slave sequencing: address phase, one wait cycle, data ready
	// the wait state lets every answer come from a flop, at the cost of one cycle per transfer
	always_comb begin
		bus_d = bus_q;
		idx_d = idx_q;
		wr_d = wr_q;
		ready_d = 1'b1;
		resp_d = HRESP_OKAY;
		unique case (bus_q)
			BUS_IDLE: begin
				if (accept) begin
					idx_d = HADDR[31:ADDR_LSB];
					wr_d = HWRITE;
					ready_d = 1'b0;
					bus_d = BUS_EXEC;
				end
			end
			BUS_EXEC: begin
				bus_d = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			bus_q <= BUS_IDLE;
			idx_q <= '0;
			wr_q <= 1'b0;
			ready_q <= 1'b1;
			resp_q <= HRESP_OKAY;
		end else begin
			bus_q <= bus_d;
			idx_q <= idx_d;
			wr_q <= wr_d;
			ready_q <= ready_d;
			resp_q <= resp_d;
		end
	end

	// read mux, unmapped indexes read zero
	// the answer is registered so HRDATA stays put until the next read
	always_comb begin
		rdata_d = rdata_q;
		if (exec_rd) begin
			unique case (idx_q)
				IDX_IRQ_STATUS: rdata_d = {25'h0, status};
				IDX_IRQ_ENABLE: rdata_d = en_q;
				IDX_IRQ_DISABLE: rdata_d = en_q; // [R17]
				IDX_FRAME_INTERVAL: rdata_d = fmi_q; // [R16]
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// interrupt enables: set through enable, cleared through disable
	always_comb begin
		en_d = en_q;
		if (exec_wr && idx_q == IDX_IRQ_ENABLE) begin
			en_d = en_q | wbits;
		end
		if (exec_wr && idx_q == IDX_IRQ_DISABLE) begin
			// zeros leave bits alone; reserved bits stay zero [R1] [R3] [R4] [R5] [R6] [R17]
			en_d = en_q & ~wbits;
		end
		if (cres_q) begin
			en_d[BIT_MASTER] = 1'b1; // [R2]
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			en_q <= IRQ_ENABLE_RESET; // [R2]
		end else begin
			en_q <= en_d;
		end
	end

	// controller reset command: one-cycle pulse, the bit itself reads zero
	// acting one edge after the write keeps the reset out of the write's own cycle
	always_comb begin
		cres_d = exec_wr & (idx_q == IDX_CMD_STATUS) & HWDATA[BIT_CTRL_RESET];
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			cres_q <= 1'b0;
		end else begin
			cres_q <= cres_d;
		end
	end

	// frame interval register; toggle and largest packet are plain software bits
	always_comb begin
		fmi_d = fmi_q;
		if (exec_wr && idx_q == IDX_FRAME_INTERVAL) begin
			fmi_d = HWDATA & FMI_WRITE_MASK; // [R7] [R12] [R14] [R16] [R19]
		end
		// for the interval field only, the reset command wins over a write in the same cycle
		if (cres_q) begin
			fmi_d.interval = FI_NOMINAL; // [R9]
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			fmi_q <= FMI_RESET; // [R8] [R19]
		end else begin
			fmi_q <= fmi_d;
		end
	end

	// values handed to the frame timing logic at each frame start
	always_comb begin
		act_d = act_q;
		lpc_d = lpc_q;
		if (EVT.frame_start) begin
			act_d = fmi_q.interval; // [R15]
			lpc_d = fmi_q.largest; // [R13]
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			act_q <= FI_NOMINAL;
			lpc_q <= '0;
		end else begin
			act_q <= act_d;
			lpc_q <= lpc_d;
		end
	end

	// status and the interrupt line live in their own unit so that the
	// set-beats-clear order is decided in one place only
	hcfi_irq_unit u_irq (
		.clk(MCLK),
		.rst(RST),
		.evt(EVT),
		.rd_clr(exec_rd && idx_q == IDX_IRQ_STATUS),
		.enables(en_q),
		.status_q(status),
		.irq_q(irq)
	);

	assign HRDATA = rdata_q;
	assign HREADYOUT = ready_q;
	assign HRESP = resp_q;
	assign IRQ = irq;
	assign CTRL_RESET_PULSE = cres_q;
	assign ACTIVE_INTERVAL = act_q;
	assign LARGEST_PKT_CNT = lpc_q;

	// all checks share the bus clock and are off while reset is held
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	sequence s_addr_taken;
		bus_q == BUS_IDLE && accept;
	endsequence

	sequence s_one_wait;
		!HREADYOUT ##1 HREADYOUT;
	endsequence

	chk_bus_one_wait: assert property (s_addr_taken |=> s_one_wait)
		else $error("transfer did not complete after exactly one wait cycle");

	chk_master_disable: assert property ( // [R1]
		exec_wr && idx_q == IDX_IRQ_DISABLE && HWDATA[31] && !cres_q |=> !en_q[BIT_MASTER] ##1 !IRQ)
		else $error("master enable survived a disable write");

	chk_hub_zero_keeps: assert property ( // [R3]
		exec_wr && idx_q == IDX_IRQ_DISABLE && !HWDATA[BIT_HUB] |=> $stable(en_q[BIT_HUB]))
		else $error("zero written to disable changed the hub change enable");

	chk_event_disable: assert property ( // [R4]
		exec_wr && idx_q == IDX_IRQ_DISABLE && HWDATA[BIT_FATAL] && HWDATA[BIT_WRAP]
		|=> !en_q[BIT_FATAL] && !en_q[BIT_WRAP])
		else $error("fatal or wrap enable not cleared by disable write");

	chk_irq_gating: assert property ( // [R18]
		IRQ |-> $past(en_q[BIT_MASTER]) && (|($past(status | EVT) & $past(en_q[NUM_EVT-1:0]))))
		else $error("interrupt raised without status, enable and master");

	chk_ctrl_reset_fi: assert property ( // [R9]
		cres_q |=> fmi_q.interval == FI_NOMINAL && en_q[BIT_MASTER])
		else $error("controller reset did not restore the nominal interval");

	chk_sof_loads: assert property ( // [R13]
		EVT.frame_start |=> LARGEST_PKT_CNT == $past(fmi_q.largest)
		&& ACTIVE_INTERVAL == $past(fmi_q.interval))
		else $error("frame start did not load interval and largest packet");

	chk_disable_reads: assert property ( // [R17]
		exec_rd && idx_q == IDX_IRQ_DISABLE |=> HREADYOUT && HRDATA == $past(en_q))
		else $error("disable read did not return the enables");

	chk_fi_reserved: assert property (fmi_q.rsvd == 2'h0 && en_q[30:7] == '0) // [R19]
		else $error("reserved bits became set");

	// a disable write in its data phase
	sequence s_disable_wr;
		exec_wr && idx_q == IDX_IRQ_DISABLE;
	endsequence

	chk_disable_events: assert property ( // [R5] [R6]
		s_disable_wr |=> en_q[NUM_EVT-1:0]
		== ($past(en_q[NUM_EVT-1:0]) & ~$past(HWDATA[NUM_EVT-1:0] & EVENT_MASK)))
		else $error("disable write did not clear exactly the written event enables");

	chk_master_gates_irq: assert property ( // [R1]
		!en_q[BIT_MASTER] |=> !IRQ)
		else $error("interrupt raised while the master enable was off");

	chk_interval_write: assert property ( // [R7] [R16]
		exec_wr && idx_q == IDX_FRAME_INTERVAL && !cres_q
		|=> fmi_q == $past(HWDATA & FMI_WRITE_MASK))
		else $error("interval register did not take the written word");

	chk_frame_hold: assert property ( // [R15]
		!EVT.frame_start |=> $stable(ACTIVE_INTERVAL) && $stable(LARGEST_PKT_CNT))
		else $error("frame values changed without a frame start");
endmodule // hcfi_regbank
`default_nettype wire

// ==== hcfi_regbank_tb.sv ====
// Purpose: self-checking bench for the interrupt gate and frame interval register bank
// Assumes: one AHB-Lite master, HREADY looped back from HREADYOUT
// Notes: events are one-cycle pulses driven right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module hcfi_regbank_tb;
	import hcfi_pkg::*;
	logic MCLK, RST, HWRITE, HREADYOUT, HRESP, IRQ, CTRL_RESET_PULSE;
	logic [31:0] HADDR, HWDATA, HRDATA;
	logic [1:0] HTRANS;
	logic [13:0] ACTIVE_INTERVAL;
	logic [14:0] LARGEST_PKT_CNT;
	hcfi_evt_s EVT;
	int err_count = 0, total_checks = 0, cycles = 0;
	int ev_bits[6] = '{6, 5, 4, 3, 2, 0};
	hcfi_regbank hcfi_regbank_inst (.MCLK(MCLK), .RST(RST), .HSEL(1'b1), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EVT(EVT), .IRQ(IRQ),
		.CTRL_RESET_PULSE(CTRL_RESET_PULSE), .ACTIVE_INTERVAL(ACTIVE_INTERVAL),
		.LARGEST_PKT_CNT(LARGEST_PKT_CNT));
	initial begin
		MCLK = 1'b0;
		forever #12.5 MCLK = ~MCLK;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// hang guard: the whole run needs only a few hundred cycles
	always @(posedge MCLK) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [29:0] i, input logic [31:0] wd,
		output logic [31:0] rd);
		HTRANS <= HTRANS_NONSEQ;
		HADDR <= {i, 2'h0};
		HWRITE <= w;
		do @(posedge MCLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= wd;
		do @(posedge MCLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
		chk("hresp", 32'(HRESP_OKAY), 32'(HRESP));
	endtask
	task automatic pulse(input logic [6:0] v);
		EVT <= hcfi_evt_s'(v);
		@(posedge MCLK);
		EVT <= hcfi_evt_s'(7'h00);
		@(posedge MCLK);
	endtask
	task automatic t_reset();
		logic [31:0] r;
		bus(0, IDX_IRQ_ENABLE, 32'h0, r);
		chk("enable_rst", 32'h80000000, r);
		bus(0, IDX_FRAME_INTERVAL, 32'h0, r);
		chk("fmi_rst", 32'h00002EDF, r);
		chk("active_rst", 32'(FI_NOMINAL), 32'(ACTIVE_INTERVAL));
		chk("largest_rst", 32'h0, 32'(LARGEST_PKT_CNT));
		bus(0, 30'h1F, 32'h0, r);
		chk("unmapped", 32'h0, r);
		$display("test reset done");
	endtask
	task automatic t_events();
		logic [31:0] r;
		bus(1, IDX_IRQ_ENABLE, 32'hFFFFFFFF, r);
		bus(0, IDX_IRQ_ENABLE, 32'h0, r);
		chk("enable_rsvd", IRQ_LAYOUT_MASK, r);
		bus(1, IDX_IRQ_DISABLE, 32'h7FFFFFFF, r);
		bus(0, IDX_IRQ_DISABLE, 32'h0, r);
		chk("disable_read", 32'h80000000, r);
		foreach (ev_bits[k]) begin
			bus(1, IDX_IRQ_ENABLE, 32'h1 << ev_bits[k], r);
			pulse(7'h01 << ev_bits[k]);
			chk("irq_on", 32'h1, 32'(IRQ));
			bus(0, IDX_IRQ_STATUS, 32'h0, r);
			chk("status", 32'h1 << ev_bits[k], r);
			@(posedge MCLK);
			chk("irq_clr", 32'h0, 32'(IRQ));
			bus(1, IDX_IRQ_DISABLE, 32'h0, r);
			bus(0, IDX_IRQ_ENABLE, 32'h0, r);
			chk("zero_kept", 32'h80000000 | (32'h1 << ev_bits[k]), r);
			bus(1, IDX_IRQ_DISABLE, 32'h1 << ev_bits[k], r);
			pulse(7'h01 << ev_bits[k]);
			chk("irq_off", 32'h0, 32'(IRQ));
			bus(0, IDX_IRQ_STATUS, 32'h0, r);
		end
		bus(1, IDX_IRQ_ENABLE, 32'h7D, r);
		bus(1, IDX_IRQ_DISABLE, 32'h80000000, r);
		pulse(7'h7D);
		chk("master_off", 32'h0, 32'(IRQ));
		bus(0, IDX_IRQ_ENABLE, 32'h0, r);
		chk("master_clr", 32'h7D, r);
		bus(1, IDX_IRQ_ENABLE, 32'h80000000, r);
		@(posedge MCLK);
		chk("master_on", 32'h1, 32'(IRQ));
		bus(0, IDX_IRQ_STATUS, 32'h0, r);
		bus(1, IDX_IRQ_DISABLE, 32'h7D, r);
		$display("test events done");
	endtask
	task automatic t_frame();
		logic [31:0] r;
		bus(1, IDX_FRAME_INTERVAL, 32'h9234C123, r);
		bus(0, IDX_FRAME_INTERVAL, 32'h0, r);
		chk("fmi_rw", 32'h92340123, r);
		chk("active_hold", 32'(FI_NOMINAL), 32'(ACTIVE_INTERVAL));
		pulse(7'h04);
		chk("active_new", 32'h0123, 32'(ACTIVE_INTERVAL));
		chk("largest_new", 32'h1234, 32'(LARGEST_PKT_CNT));
		bus(1, IDX_IRQ_DISABLE, 32'h80000000, r);
		bus(1, IDX_CMD_STATUS, 32'h1, r);
		chk("reset_pulse", 32'h1, 32'(CTRL_RESET_PULSE));
		bus(0, IDX_FRAME_INTERVAL, 32'h0, r);
		chk("pulse_end", 32'h0, 32'(CTRL_RESET_PULSE));
		chk("ctrl_reset", 32'h92342EDF, r);
		bus(0, IDX_IRQ_ENABLE, 32'h0, r);
		chk("master_sw_rst", 32'h80000000, r);
		bus(1, IDX_FRAME_INTERVAL, 32'h12340123, r);
		bus(0, IDX_FRAME_INTERVAL, 32'h0, r);
		chk("restore", 32'h12340123, r);
		bus(0, IDX_IRQ_STATUS, 32'h0, r);
		$display("test frame done");
	endtask
	initial begin
		RST = 1'b1;
		HADDR = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HWDATA = 32'h0;
		EVT = hcfi_evt_s'(7'h00);
		repeat (2) @(posedge MCLK);
		RST <= 1'b0;
		@(posedge MCLK);
		t_reset();
		t_events();
		t_frame();
		print_verdict();
	end
endmodule // hcfi_regbank_tb
`default_nettype wire
